// *** bench/spd_host.sv ***
`timescale 1ns/100ps
`default_nettype none
// Host side of the serial link; clock stands low between frames
module spd_host (
    input  wire logic clk_in,
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      sdi_out,
    input  wire logic sdo_in
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out  = 1'b0;
    end
    // One frame of n clocks; each bit read just before the fall that moves it
    task automatic xfer(input logic [7:0] cmd, input int n, output logic [7:0] rd);
        rd = 8'h00;
        cs_n_out = 1'b0;
        sdi_out  = cmd[7];
        repeat (6) @(negedge clk_in);
        for (int i = 0; i < n; i++) begin
            sclk_out = 1'b1;
            repeat (4) @(negedge clk_in);
            rd[7-i] = sdo_in;
            sclk_out = 1'b0;
            sdi_out  = (i < 7) ? cmd[6-i] : ~sdi_out;
            repeat (4) @(negedge clk_in);
        end
        cs_n_out = 1'b1;
        sdi_out  = ~sdi_out; // Ignored line toggles at once, which after an eight-clock frame restores the last bit; eight idle clocks follow
        repeat (8) @(negedge clk_in);
    endtask
endmodule
`default_nettype wire

// *** bench/spd_predriver_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
// Pin-level checker; parallel, drain and battery pins are asynchronous
module spd_predriver_properties
    import spd_pkg::*;
#(
    parameter bit          RETRY_MODE   = 1'b0,
    parameter bit          HAS_PARALLEL = 1'b1,
    parameter int unsigned MASK_N       = MASK_CYC,
    parameter int unsigned CONFIRM_N    = CONFIRM_CYC,
    parameter int unsigned WIDTH_N      = WIDTH_CYC
) (
    input wire logic              REF_CLK_IN,
    input wire logic              SYS_RST_IN,
    input wire logic              SCLK_IN,
    input wire logic              CS_N_IN,
    input wire logic              SDI_IN,
    input wire logic              SDO_OUT,
    input wire logic              SDO_OE_OUT,
    input wire logic [NUM_CH-1:0] PARALLEL_CHANNEL_ON_IN,
    input wire logic [NUM_CH-1:0] CHANNEL_DRAIN_SENSE_IN,
    input wire logic              BAT_OVERVOLT_IN,
    input wire logic [NUM_CH-1:0] CHANNEL_GATE_DRIVE_OUT,
    input wire logic              FAULT_FLAG_N_OUT,
    input wire logic              FAULT_FLAG_N_OE_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // Slack of two cycles covers the pin synchronisers
    localparam int SHORT_MIN = MASK_N + CONFIRM_N - 2;
    localparam int SHORT_MAX = MASK_N + CONFIRM_N + 8;
    // Retry pulses into a short end with exactly one pulse width counted
    localparam int PULSE_LEN = RETRY_MODE ? WIDTH_N : SHORT_MIN;
    logic [15:0] hot_cnt_ff;    // Cycles channel 0 on into a high drain
    // Count restarts whenever the drain drops or the gate turns off
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN || !(CHANNEL_GATE_DRIVE_OUT[0] && CHANNEL_DRAIN_SENSE_IN[0])) begin
            hot_cnt_ff <= 16'h0000;
        end else begin
            hot_cnt_ff <= hot_cnt_ff + 16'h0001;
        end
    end
    // Gate 0 cut while its drain read high with the gate still on
    sequence s_short_cut;
        $fell(CHANNEL_GATE_DRIVE_OUT[0]) && $past(CHANNEL_DRAIN_SENSE_IN[0]);
    endsequence
    a_sdo_held_high: assert property (SCLK_IN [*2] |-> $stable(SDO_OUT))
        else $error("serial out moved while serial clock high");
    a_oe_in_frame: assert property (!CS_N_IN [*5] |-> SDO_OE_OUT)
        else $error("serial out not driven inside frame");
    a_oe_idle_off: assert property (CS_N_IN [*5] |-> !SDO_OE_OUT)
        else $error("serial out driven while deselected");
    a_ovr_gates_off: assert property (BAT_OVERVOLT_IN [*5] |-> CHANNEL_GATE_DRIVE_OUT == 6'h00)
        else $error("gate on during overvoltage");
    a_ovr_flag_low: assert property (BAT_OVERVOLT_IN [*5] |-> FAULT_FLAG_N_OE_OUT)
        else $error("flag idle during overvoltage");
    a_par_gate_on: assert property (HAS_PARALLEL && $rose(PARALLEL_CHANNEL_ON_IN[0])
        && !BAT_OVERVOLT_IN |-> ##[1:6] CHANNEL_GATE_DRIVE_OUT[0])
        else $error("parallel request did not turn gate on");
    a_short_bound: assert property (hot_cnt_ff <= SHORT_MAX)
        else $error("shorted channel left on too long");
    a_short_early: assert property (s_short_cut |->
        hot_cnt_ff >= SHORT_MIN || hot_cnt_ff == PULSE_LEN)
        else $error("short acted on inside mask");
    a_short_flag: assert property (s_short_cut |-> ##[0:4] FAULT_FLAG_N_OE_OUT)
        else $error("short cut without flag");
    a_flag_drive_low: assert property (FAULT_FLAG_N_OUT == 1'b0)
        else $error("flag pin drives high");
endmodule
bind spd_predriver spd_predriver_properties #(.RETRY_MODE(RETRY_MODE),
    .HAS_PARALLEL(HAS_PARALLEL), .MASK_N(MASK_N), .CONFIRM_N(CONFIRM_N), .WIDTH_N(WIDTH_N))
    i_props (.*);
`default_nettype wire

// *** bench/spd_predriver_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module spd_predriver_test;
    import spd_pkg::*;
    localparam int unsigned MASK_T = 40;    // Shortened mask
    localparam int unsigned PERIOD_T = 200; // Shortened retry period
    localparam int unsigned WIDTH_T = 20;   // Shortened retry pulse
    logic        clk, rst, bat;
    logic [5:0]  par, open, short;          // Parallel requests, load faults
    wire  logic  sclk, cs_n, sdi, sdo, sdo_oe, flag, flag_oe;
    wire  logic [5:0] gate, drain;
    wire  logic [7:0] gate8 = {2'h0, gate};
    wire  logic [5:0] gate2, drain2;        // Retry build, no parallel pins
    wire  logic  flag2_oe;
    wire  logic [7:0] gate28 = {2'h0, gate2};
    logic [7:0]  rd;
    int          errors, check_count;
    // Load model: on pulls drain low, off lets it float high
    assign drain = short | (~gate & ~open);
    assign drain2 = short | (~gate2 & ~open);
    spd_host i_spd_host (.clk_in(clk), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
        .sdo_in(sdo));
    spd_predriver #(.MASK_N(MASK_T), .CONFIRM_N(10), .PERIOD_N(PERIOD_T), .WIDTH_N(WIDTH_T))
    i_spd_predriver (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .SCLK_IN(sclk), .CS_N_IN(cs_n),
        .SDI_IN(sdi), .SDO_OUT(sdo), .SDO_OE_OUT(sdo_oe), .PARALLEL_CHANNEL_ON_IN(par),
        .CHANNEL_DRAIN_SENSE_IN(drain), .BAT_OVERVOLT_IN(bat),
        .CHANNEL_GATE_DRIVE_OUT(gate), .FAULT_FLAG_N_OUT(flag),
        .FAULT_FLAG_N_OE_OUT(flag_oe));
    spd_predriver #(.RETRY_MODE(1'b1), .HAS_PARALLEL(1'b0), .MASK_N(MASK_T), .CONFIRM_N(10),
        .PERIOD_N(PERIOD_T), .WIDTH_N(WIDTH_T))
    i_spd_predriver_retry (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .SCLK_IN(sclk), .CS_N_IN(cs_n),
        .SDI_IN(sdi), .SDO_OUT(), .SDO_OE_OUT(), .PARALLEL_CHANNEL_ON_IN(par),
        .CHANNEL_DRAIN_SENSE_IN(drain2), .BAT_OVERVOLT_IN(bat),
        .CHANNEL_GATE_DRIVE_OUT(gate2), .FAULT_FLAG_N_OUT(),
        .FAULT_FLAG_N_OE_OUT(flag2_oe));
    initial clk = 1'b0;
    always #25 clk = ~clk;
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic close_out();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Full frames: first two bits dropped, rest land on the gates
    task automatic t_serial();
        i_spd_host.xfer(8'h00, 8, rd);
        check("first read", rd, 8'h00);
        check("oe idle", {7'h0, sdo_oe}, 8'h00);
        check("flag pin", {7'h0, flag}, 8'h00);
        i_spd_host.xfer(8'hc5, 8, rd);
        check("gates c5", gate8, 8'h05);
        i_spd_host.xfer(8'hfa, 8, rd);
        check("gates fa", gate8, 8'h3a);
    endtask
    // Open load on channel 3, read back, then a frame of three clocks
    task automatic t_open();
        i_spd_host.xfer(8'h05, 8, rd);
        open = 6'h08;
        wt(MASK_T + 20);
        check("open flag", {7'h0, flag_oe}, 8'h01);
        i_spd_host.xfer(8'h05, 8, rd);
        check("open word", rd, 8'h08);
        i_spd_host.xfer(8'hff, 3, rd);
        check("short frame", gate8, 8'h08);
        open = 6'h00;
        i_spd_host.xfer(8'h00, 8, rd);
        wt(MASK_T + 20);
        check("flag clear", {7'h0, flag_oe}, 8'h00);
    endtask
    // Parallel pins OR with serial bits, no frame needed
    task automatic t_parallel();
        i_spd_host.xfer(8'h05, 8, rd);
        par = 6'h30;
        wt(8);
        check("par or", gate8, 8'h35);
        check("no par pins", gate28, 8'h05);
        par = 6'h00;
        wt(8);
        check("par off", gate8, 8'h05);
    endtask
    // Short on channel 0: mask, cut, read, then the two ways to clear it
    task automatic t_short();
        i_spd_host.xfer(8'h04, 8, rd);
        short = 6'h01;
        i_spd_host.xfer(8'h05, 8, rd);
        wt(30);
        check("in mask", gate8, 8'h05);
        wt(40);
        check("cut", gate8, 8'h04);
        check("short flag", {7'h0, flag_oe}, 8'h01);
        i_spd_host.xfer(8'h04, 8, rd);
        check("short word", rd, 8'h01);
        short = 6'h00;
        i_spd_host.xfer(8'h05, 8, rd);
        wt(10);
        check("serial clear", gate8, 8'h05);
        check("flag gone", {7'h0, flag_oe}, 8'h00);
        i_spd_host.xfer(8'h04, 8, rd);
        short = 6'h01;
        par = 6'h01;
        wt(80);
        check("par cut", gate8, 8'h04);
        short = 6'h00;
        wt(8);
        check("stays cut", gate8, 8'h04);
        par = 6'h00;
        wt(8);
        par = 6'h01;
        wt(8);
        check("par clear", gate8, 8'h05);
        par = 6'h00;
    endtask
    // Battery overvoltage: all off, top fault bit, recovery
    task automatic t_ovr();
        bat = 1'b1;
        wt(8);
        check("ovr gates", gate8, 8'h00);
        check("ovr flag", {7'h0, flag_oe}, 8'h01);
        i_spd_host.xfer(8'h04, 8, rd);
        check("ovr word", rd, 8'h80);
        bat = 1'b0;
        wt(10);
        check("ovr gone", gate8, 8'h04);
    endtask
    // Retry build: pulses while shorted, resumes once the short is gone
    task automatic t_retry();
        int n;
        int m;
        short = 6'h01;
        i_spd_host.xfer(8'h05, 8, rd);
        wt(80);
        check("retry off", gate28, 8'h04);
        check("retry flag", {7'h0, flag2_oe}, 8'h01);
        n = 0;
        while (!gate2[0] && n < 300) begin
            n++;
            wt(1);
        end
        m = 0;
        while (gate2[0] && m < 100) begin
            m++;
            wt(1);
        end
        check("pulse width", 8'(m), 8'(WIDTH_T));
        while (!gate2[0] && m < 300) begin
            m++;
            wt(1);
        end
        check("pulse period", 8'(m), 8'(PERIOD_T));
        check("still flagged", {7'h0, flag2_oe}, 8'h01);
        // Remove the short only while the gate is off
        m = 0;
        while (gate2[0] && m < 100) begin
            m++;
            wt(1);
        end
        short = 6'h00;
        wt(PERIOD_T + 40);
        check("retry resumed", gate28, 8'h05);
        check("retry unflag", {7'h0, flag2_oe}, 8'h00);
        check("latched stays", gate8, 8'h04);
    endtask
    // Main sequence
    initial begin
        errors = 0;
        check_count = 0;
        rst = 1'b1;
        bat = 1'b0;
        par = 6'h00;
        open = 6'h00;
        short = 6'h00;
        wt(6);
        rst = 1'b0;
        wt(4);
        t_serial();
        t_open();
        t_parallel();
        t_short();
        t_ovr();
        t_retry();
        close_out();
    end
    // Run needs about 2200 cycles; cut off far beyond that
    initial begin
        #1_000_000;
        errors++;
        close_out();
    end
endmodule
`default_nettype wire

// *** rtl/spd_channel.sv ***
`timescale 1ns/100ps
`default_nettype none
// One channel: masks, short deglitch, latch or retry, open-load watch
module spd_channel
    import spd_pkg::*;
#(
    parameter bit    RETRY_MODE = 1'b0,
    parameter int unsigned MASK_N    = MASK_CYC,
    parameter int unsigned CONFIRM_N = CONFIRM_CYC,
    parameter int unsigned PERIOD_N  = PERIOD_CYC,
    parameter int unsigned WIDTH_N   = WIDTH_CYC
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic request_in,     // OR of serial and parallel request
    input  wire logic drain_high_in,  // Drain above reference, synchronised
    input  wire logic overvolt_in,    // Battery overvoltage, synchronised
    output logic      gate_on_out,
    output logic      fault_out       // Live load fault for this channel
);
    spd_ch_state_t   state_ff;
    logic [TMR_W-1:0] tmr_ff;         // Mask / pulse timer
    logic [TMR_W-1:0] per_ff;         // Retry period timer
    logic [TMR_W-1:0] dg_ff;          // Short deglitch counter

    // Gate on only in the on-side states, never while overvoltage
    always_comb begin
        gate_on_out = !overvolt_in && (state_ff == SPD_ON_MASK || state_ff == SPD_ON_WATCH
                      || state_ff == SPD_RETRY_PULSE);
    end

    // Main supervisor; overvoltage forces off and blocks load reporting
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_ff  <= SPD_OFF_MASK;
            tmr_ff    <= '0;
            per_ff    <= '0;
            dg_ff     <= '0;
            fault_out <= 1'b0;
        end else if (overvolt_in) begin
            // Restart from off; load faults are suppressed meanwhile
            state_ff  <= SPD_OFF_MASK;
            tmr_ff    <= '0;
            dg_ff     <= '0;
            fault_out <= 1'b0;
        end else begin
            unique case (state_ff)
                SPD_OFF_MASK: begin
                    if (request_in) begin
                        state_ff <= SPD_ON_MASK;
                        tmr_ff   <= '0;
                    end else if (tmr_ff == TMR_W'(MASK_N - 1)) begin
                        state_ff <= SPD_OFF_WATCH;
                    end else begin
                        tmr_ff <= tmr_ff + 1'b1;
                    end
                    fault_out <= 1'b0;
                end
                SPD_OFF_WATCH: begin
                    // Open load: drain pulled below reference while off
                    fault_out <= !drain_high_in;
                    if (request_in) begin
                        state_ff  <= SPD_ON_MASK;
                        tmr_ff    <= '0;
                        fault_out <= 1'b0;
                    end
                end
                SPD_ON_MASK: begin
                    fault_out <= 1'b0;
                    dg_ff     <= '0;
                    if (!request_in) begin
                        state_ff <= SPD_OFF_MASK;
                        tmr_ff   <= '0;
                    end else if (tmr_ff == TMR_W'(MASK_N - 1)) begin
                        state_ff <= SPD_ON_WATCH;
                    end else begin
                        tmr_ff <= tmr_ff + 1'b1;
                    end
                end
                SPD_ON_WATCH: begin
                    if (!request_in) begin
                        state_ff <= SPD_OFF_MASK;
                        tmr_ff   <= '0;
                    end else if (!drain_high_in) begin
                        dg_ff <= '0;            // Glitch gone, restart deglitch
                    end else if (dg_ff == TMR_W'(CONFIRM_N - 1)) begin
                        fault_out <= 1'b1;
                        tmr_ff    <= '0;
                        per_ff    <= '0;
                        state_ff  <= RETRY_MODE ? SPD_RETRY_WAIT : SPD_SHORT_HOLD;
                    end else begin
                        dg_ff <= dg_ff + 1'b1;
                    end
                end
                SPD_SHORT_HOLD: begin
                    // Latched off until the request drops and returns
                    if (!request_in) begin
                        state_ff  <= SPD_OFF_MASK;
                        tmr_ff    <= '0;
                        fault_out <= 1'b0;
                    end
                end
                SPD_RETRY_PULSE: begin
                    per_ff <= per_ff + 1'b1;
                    if (!request_in) begin
                        state_ff  <= SPD_OFF_MASK;
                        tmr_ff    <= '0;
                        fault_out <= 1'b0;
                    end else if (tmr_ff == TMR_W'(WIDTH_N - 1)) begin
                        // End of pulse: drain sampled with gate still on
                        if (!drain_high_in) begin
                            state_ff  <= SPD_ON_WATCH;
                            dg_ff     <= '0;
                            fault_out <= 1'b0;
                        end else begin
                            state_ff <= SPD_RETRY_WAIT;
                        end
                    end else begin
                        tmr_ff <= tmr_ff + 1'b1;
                    end
                end
                SPD_RETRY_WAIT: begin
                    if (!request_in) begin
                        state_ff  <= SPD_OFF_MASK;
                        tmr_ff    <= '0;
                        fault_out <= 1'b0;
                    end else if (per_ff == TMR_W'(PERIOD_N - 1)) begin
                        state_ff <= SPD_RETRY_PULSE;
                        per_ff   <= '0;
                        tmr_ff   <= '0;
                    end else begin
                        per_ff <= per_ff + 1'b1;
                    end
                end
                default: state_ff <= SPD_OFF_MASK;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** rtl/spd_pkg.sv ***
package spd_pkg;
    // Channel and frame geometry
    localparam int unsigned NUM_CH        = 6;
    localparam int unsigned FRAME_BITS    = 8;
    localparam int unsigned CMD_LSB       = 0;     // Last six bits shifted are commands
    localparam int unsigned BAT_FAULT_POS = 7;     // Over-battery bit, MSB of returned byte
    // Timing figures in their own units
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned MASK_TIME_US   = 60;
    localparam int unsigned CONFIRM_TIME_US = 8;
    localparam int unsigned RETRY_PERIOD_MS = 10;
    localparam int unsigned RETRY_WIDTH_US = 68;
    // Derived cycle counts (typical values, no rounding needed at 20 MHz)
    localparam int unsigned MASK_CYC    = CLK_HZ / 1_000_000 * MASK_TIME_US;
    localparam int unsigned CONFIRM_CYC = CLK_HZ / 1_000_000 * CONFIRM_TIME_US;
    localparam int unsigned PERIOD_CYC  = CLK_HZ / 1_000 * RETRY_PERIOD_MS;
    localparam int unsigned WIDTH_CYC   = CLK_HZ / 1_000_000 * RETRY_WIDTH_US;
    localparam int unsigned TMR_W       = 18;
    // Reset values
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [5:0] CMD_RST   = 6'h00;
    // Per-channel supervisor states
    typedef enum logic [2:0] {
        SPD_OFF_MASK,
        SPD_OFF_WATCH,
        SPD_ON_MASK,
        SPD_ON_WATCH,
        SPD_SHORT_HOLD,
        SPD_RETRY_PULSE,
        SPD_RETRY_WAIT
    } spd_ch_state_t;
endpackage

// *** rtl/spd_predriver.sv ***
`timescale 1ns/100ps
`default_nettype none
module spd_predriver
    import spd_pkg::*;
#(
    parameter bit          RETRY_MODE   = 1'b0,
    parameter bit          HAS_PARALLEL = 1'b1,
    parameter int unsigned MASK_N       = MASK_CYC,
    parameter int unsigned CONFIRM_N    = CONFIRM_CYC,
    parameter int unsigned PERIOD_N     = PERIOD_CYC,  // At most 262144 cycles, the 18-bit timer range
    parameter int unsigned WIDTH_N      = WIDTH_CYC
) (
    input  wire logic              REF_CLK_IN,
    input  wire logic              SYS_RST_IN,
    input  wire logic              SCLK_IN,
    input  wire logic              CS_N_IN,
    input  wire logic              SDI_IN,
    output logic                   SDO_OUT,
    output logic                   SDO_OE_OUT,
    input  wire logic [NUM_CH-1:0] PARALLEL_CHANNEL_ON_IN,
    input  wire logic [NUM_CH-1:0] CHANNEL_DRAIN_SENSE_IN,
    input  wire logic              BAT_OVERVOLT_IN,
    output logic [NUM_CH-1:0]      CHANNEL_GATE_DRIVE_OUT,
    output logic                   FAULT_FLAG_N_OUT,
    output logic                   FAULT_FLAG_N_OE_OUT
);
    import spd_pkg::*;

    localparam int unsigned SW = 3 + NUM_CH + NUM_CH + 1;

    logic [SW-1:0]     sync_w;        // Synchronised pins
    logic              sclk_s;
    logic              cs_n_s;
    logic              sdi_s;
    logic [NUM_CH-1:0] par_s;
    logic [NUM_CH-1:0] drain_s;
    logic              ovp_s;
    logic              sclk_d_ff;     // Previous SCLK for edge find
    logic              cs_n_d_ff;     // Previous CS
    logic [7:0]        shift_ff;      // Input shift register
    logic [7:0]        out_ff;        // Fault output register
    logic [7:0]        cap_ff;        // Fault word captured at CS fall
    logic [3:0]        bitcnt_ff;     // Rising edges seen this frame
    logic [NUM_CH-1:0] cmd_ff;        // Output control register
    logic [NUM_CH-1:0] request;       // Combined per-channel request
    logic [NUM_CH-1:0] gate_w;
    logic [NUM_CH-1:0] fault_w;
    logic [7:0]        fault_word;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              cs_fall;
    logic              cs_rise;

    // All pin inputs cross through two flops
    spd_sync #(.W(SW)) u_sync (
        .clk_in   (REF_CLK_IN),
        .rst_in   (SYS_RST_IN),
        .async_in ({SCLK_IN, ~CS_N_IN, SDI_IN, PARALLEL_CHANNEL_ON_IN,
                    CHANNEL_DRAIN_SENSE_IN, BAT_OVERVOLT_IN}),
        .sync_out (sync_w)
    );

    // CS inverted through the synchroniser so reset reads as deselected
    always_comb begin
        sclk_s  = sync_w[SW-1];
        cs_n_s  = ~sync_w[SW-2];
        sdi_s   = sync_w[SW-3];
        par_s   = HAS_PARALLEL ? sync_w[2*NUM_CH:NUM_CH+1] : '0;
        drain_s = sync_w[NUM_CH:1];
        ovp_s   = sync_w[0];
    end

    // Edge detection of the synchronised link lines
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            sclk_d_ff <= 1'b0;
            cs_n_d_ff <= 1'b1;
        end else begin
            sclk_d_ff <= sclk_s;
            cs_n_d_ff <= cs_n_s;
        end
    end

    always_comb begin
        sclk_rise = sclk_s && !sclk_d_ff && !cs_n_s;
        sclk_fall = !sclk_s && sclk_d_ff && !cs_n_s;
        cs_fall   = !cs_n_s && cs_n_d_ff;
        cs_rise   = cs_n_s && !cs_n_d_ff;
    end

    // Fault word: channels in bits 0-5, battery in the MSB
    always_comb begin
        fault_word                = 8'h00;
        fault_word[NUM_CH-1:0]    = fault_w;
        fault_word[BAT_FAULT_POS] = ovp_s;
    end

    // Input shift register; SDI ignored while deselected
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            shift_ff  <= SHIFT_RST;
            cap_ff    <= SHIFT_RST;
            bitcnt_ff <= 4'h0;
        end else if (cs_fall) begin
            // Preload with captured faults so a short frame returns them
            shift_ff  <= fault_word;
            cap_ff    <= fault_word;
            bitcnt_ff <= 4'h0;
        end else if (sclk_rise) begin
            shift_ff <= {shift_ff[6:0], sdi_s};
            if (bitcnt_ff != 4'(FRAME_BITS))
                bitcnt_ff <= bitcnt_ff + 4'h1;
        end
    end

    // Serial output register: loaded at CS fall, shifted on SCLK fall
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            out_ff <= 8'h00;
        end else if (cs_fall) begin
            out_ff <= fault_word;
        end else if (sclk_fall) begin
            out_ff <= {out_ff[6:0], 1'b0};
        end else if (cs_rise) begin
            out_ff <= 8'h00;
        end
    end

    // SDO driven only while selected, MSB first
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            SDO_OUT    <= 1'b0;
            SDO_OE_OUT <= 1'b0;
        end else begin
            SDO_OE_OUT <= !cs_n_s;
            SDO_OUT    <= cs_fall ? fault_word[7] : out_ff[7];
        end
    end

    // Control register updated on CS rise; short frame latches fault bits
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            cmd_ff <= CMD_RST;
        end else if (cs_rise) begin
            if (bitcnt_ff == 4'(FRAME_BITS)) begin
                cmd_ff <= shift_ff[CMD_LSB +: NUM_CH];
            end else begin
                // Partial frame mixes SDI into the field, so use the capture
                cmd_ff <= cap_ff[NUM_CH-1:0];
            end
        end
    end

    // Parallel and serial requests ORed, no serial activity needed
    always_comb begin
        request = cmd_ff | par_s;
    end

    // Per-channel supervisors
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        spd_channel #(
            .RETRY_MODE (RETRY_MODE),
            .MASK_N     (MASK_N),
            .CONFIRM_N  (CONFIRM_N),
            .PERIOD_N   (PERIOD_N),
            .WIDTH_N    (WIDTH_N)
        ) u_ch (
            .clk_in        (REF_CLK_IN),
            .rst_in        (SYS_RST_IN),
            .request_in    (request[ch]),
            .drain_high_in (drain_s[ch]),
            .overvolt_in   (ovp_s),
            .gate_on_out   (gate_w[ch]),
            .fault_out     (fault_w[ch])
        );
    end

    // Registered gate drives and open-drain flag
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            CHANNEL_GATE_DRIVE_OUT <= '0;
            FAULT_FLAG_N_OUT       <= 1'b0;
            FAULT_FLAG_N_OE_OUT    <= 1'b0;
        end else begin
            CHANNEL_GATE_DRIVE_OUT <= gate_w;
            FAULT_FLAG_N_OUT       <= 1'b0;
            FAULT_FLAG_N_OE_OUT    <= |fault_word;
        end
    end
endmodule
`default_nettype wire

// *** rtl/spd_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for a bundle of asynchronous levels
module spd_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;   // First stage, read only by second stage

    // Both stages clear on reset so the gate drives start off
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule
`default_nettype wire
